/* File: design/cit_top.sv */
// counter inputs, scan snapshot and square wave timer outputs
// Operation
// - four independent counters, each with a 32-bit count value
// - per channel mode: events, period, pulse width, edge gap, quadrature
// - inputs counted up to the rate the shortest 500 ns debounce lets through
// - counts readable any time and snapshot on each paced scan
// - quadrature resolution selectable x1, x2 or x4
// - two encoders from A and B pairs, or one with Z index
// - signed 32-bit position covers two billion pulses per revolution
// - debounce per input, sixteen times from 500 ns to 25.5 ms
// - two timer outputs, each a square wave from a 16-bit divisor
// - timer frequency is 1 MHz over divisor plus one, divisor 0..65535
// - setpoint load of 65535 stops the timer output
// - host write of 65535 keeps the slowest square wave running
// - host may rewrite a divisor at any time
// - setpoint hits during acquisition reload the timer divisor
`timescale 1ns/1ps
module cit_top
	import cit_pkg::*;
#(
	parameter int DB_DIV = 1
) (
	input  wire logic        CLOCK_I,
	input  wire logic        RST_N_I,
	input  wire logic        CE_I,
	input  wire logic [3:0]  CNT_IN_I,
	input  wire logic        EXT_PACER_I,
	input  wire logic [1:0]  SETPOINT_I,
	output logic      [1:0]  TMR_O,
	output logic             SCAN_STROBE_O,
	input  wire logic [7:0]  S_AXI_AWADDR,
	input  wire logic        S_AXI_AWVALID,
	output logic             S_AXI_AWREADY,
	input  wire logic [31:0] S_AXI_WDATA,
	input  wire logic [3:0]  S_AXI_WSTRB,
	input  wire logic        S_AXI_WVALID,
	output logic             S_AXI_WREADY,
	output logic      [1:0]  S_AXI_BRESP,
	output logic             S_AXI_BVALID,
	input  wire logic        S_AXI_BREADY,
	input  wire logic [7:0]  S_AXI_ARADDR,
	input  wire logic        S_AXI_ARVALID,
	output logic             S_AXI_ARREADY,
	output logic      [31:0] S_AXI_RDATA,
	output logic      [1:0]  S_AXI_RRESP,
	output logic             S_AXI_RVALID,
	input  wire logic        S_AXI_RREADY
);
	function automatic logic [DB_W-1:0] db_lim(input logic [3:0] sel);
		int c;
		c = (DB_NS[sel] + CLK_NS - 1) / CLK_NS / DB_DIV;
		if (c < 1)
			c = 1;
		db_lim = DB_W'(c);
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] be);
		for (int b = 0; b < 4; b++)
			merge[8*b +: 8] = be[b] ? nw[8*b +: 8] : old[8*b +: 8];
	endfunction

	logic [1:0]       rst_sync_r;
	logic             rst_n;
	logic [3:0]       in_m_r;
	logic [3:0]       in_s_r;
	logic [1:0]       pac_r;
	logic             pac_d_r;
	logic [3:0]       deb_r;
	logic [3:0]       deb_d_r;
	logic [DB_W-1:0]  dbc_r [NCNT];
	logic [CFG_W-1:0] cfg_r [NCNT];
	logic [CNT_W-1:0] cnt_r [NCNT];
	logic [CNT_W-1:0] meas_r [NCNT];
	logic [CNT_W-1:0] val_r [NCNT];
	logic [CNT_W-1:0] cur [NCNT];
	logic [CNT_W-1:0] snap_r [NCNT];
	logic [1:0]       ctrl_r;
	logic [31:0]      sdiv_r;
	logic [31:0]      stk_r;
	logic [DIV_W-1:0] tdiv_r [NTMR];
	logic [DIV_W-1:0] spdiv_r [NTMR];
	logic [4:0]       acc_r;
	logic             ht_r;
	logic             us_r;
	logic             scan;
	logic             wr;
	logic             rd;
	logic [7:0]       waddr;
	logic [31:0]      wval;
	logic [3:0]       wsel;
	logic [31:0]      rdat;
	logic             rerr;

	always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
		if (!RST_N_I)
			rst_sync_r <= 2'h0;
		else
			rst_sync_r <= {rst_sync_r[0], 1'b1};
	end
	assign rst_n = rst_sync_r[1];

	// pins pass two flops; only the second stage feeds logic
	always_ff @(posedge CLOCK_I or negedge rst_n) begin
		if (!rst_n) begin
			in_m_r  <= 4'h0;
			in_s_r  <= 4'h0;
			pac_r   <= 2'h0;
			pac_d_r <= 1'b0;
		end else if (CE_I) begin
			in_m_r  <= CNT_IN_I;
			in_s_r  <= in_m_r;
			pac_r   <= {pac_r[0], EXT_PACER_I};
			pac_d_r <= pac_r[1];
		end
	end

	// 2 MHz half ticks from 25 MHz by phase accumulation (12/13 cycles)
	always_ff @(posedge CLOCK_I or negedge rst_n) begin
		if (!rst_n) begin
			acc_r <= 5'h00;
			ht_r  <= 1'b0;
			us_r  <= 1'b0;
		end else if (CE_I) begin
			if (acc_r + 5'(HT_PER_US) >= 5'(CLK_MHZ)) begin
				acc_r <= acc_r + 5'(HT_PER_US) - 5'(CLK_MHZ);
				ht_r  <= 1'b1;
				us_r  <= ~us_r;
			end else begin
				acc_r <= acc_r + 5'(HT_PER_US);
				ht_r  <= 1'b0;
			end
		end
	end

	// scan pacer: internal in 1 us ticks or external rising edge
	always_ff @(posedge CLOCK_I or negedge rst_n) begin
		if (!rst_n)
			stk_r <= 32'h0000_0000;
		else if (CE_I) begin
			if (!ctrl_r[CTRL_RUN] || scan)
				stk_r <= 32'h0000_0000;
			else if (ht_r && us_r)
				stk_r <= stk_r + 32'h0000_0001;
		end
	end
	assign scan = ctrl_r[CTRL_RUN] && (ctrl_r[CTRL_EXT] ?
		(pac_r[1] && !pac_d_r) : (stk_r >= sdiv_r));

	always_ff @(posedge CLOCK_I or negedge rst_n) begin
		if (!rst_n)
			SCAN_STROBE_O <= 1'b0;
		else if (CE_I)
			SCAN_STROBE_O <= scan;
	end

	genvar i;
	generate
	for (i = 0; i < NCNT; i++) begin : g_cnt
		localparam int NX = (i + 1) % NCNT;
		localparam int NZ = (i + 2) % NCNT;
		cit_mode_e mode;
		cit_res_e  res;
		logic      rise;
		logic      fall;
		logic      edg;
		logic      nx_rise;
		logic      a_ch;
		logic      b_ch;
		logic      up;
		logic      step;
		assign mode    = cit_mode_e'(cfg_r[i][CFG_MODE_LO +: 3]);
		assign res     = cit_res_e'(cfg_r[i][CFG_RES_LO +: 2]);
		assign rise    = deb_r[i] && !deb_d_r[i];
		assign fall    = !deb_r[i] && deb_d_r[i];
		assign edg     = cfg_r[i][CFG_FALL] ? fall : rise;
		assign nx_rise = deb_r[NX] && !deb_d_r[NX];
		assign a_ch    = deb_r[i] ^ deb_d_r[i];
		assign b_ch    = deb_r[NX] ^ deb_d_r[NX];
		assign up      = deb_r[i] ^ deb_d_r[NX];
		always_comb begin
			unique case (res)
			R_X1:    step = rise && !b_ch;
			R_X2:    step = a_ch && !b_ch;
			R_X4:    step = a_ch ^ b_ch;
			default: step = 1'b0;
			endcase
		end

		// glitches shorter than the chosen time never reach the counter
		always_ff @(posedge CLOCK_I or negedge rst_n) begin
			if (!rst_n) begin
				dbc_r[i]   <= '0;
				deb_r[i]   <= 1'b0;
				deb_d_r[i] <= 1'b0;
			end else if (CE_I) begin
				deb_d_r[i] <= deb_r[i];
				if (in_s_r[i] == deb_r[i])
					dbc_r[i] <= '0;
				else if (dbc_r[i] + 1'b1 >= db_lim(cfg_r[i][CFG_DB_LO +: 4]))
				begin
					dbc_r[i] <= '0;
					deb_r[i] <= in_s_r[i];
				end else
					dbc_r[i] <= dbc_r[i] + 1'b1;
			end
		end

		// position is two's complement, so 2^31 counts each way
		always_ff @(posedge CLOCK_I or negedge rst_n) begin
			if (!rst_n)
				cnt_r[i] <= '0;
			else if (CE_I) begin
				if (wr && wsel[CFG_CLR / 8] &&
					waddr == A_CNT_CFG + 8'(4 * i) &&
					wval[CFG_CLR])
					cnt_r[i] <= '0;
				else if (mode == M_EVENT && edg)
					cnt_r[i] <= cnt_r[i] + 1'b1;
				else if (mode == M_QUAD && cfg_r[i][CFG_INDEX] &&
					deb_r[NZ] && !deb_d_r[NZ])
					cnt_r[i] <= '0;
				else if (mode == M_QUAD && step)
					cnt_r[i] <= up ? cnt_r[i] + 1'b1
						: cnt_r[i] - 1'b1;
			end
		end

		// timed modes count system clocks of 40 ns
		always_ff @(posedge CLOCK_I or negedge rst_n) begin
			if (!rst_n) begin
				meas_r[i] <= '0;
				val_r[i]  <= '0;
			end else if (CE_I) begin
				unique case (mode)
				M_PERIOD: begin
					meas_r[i] <= edg ? '0 : meas_r[i] + 1'b1;
					if (edg)
						val_r[i] <= meas_r[i] + 1'b1;
				end
				M_WIDTH: begin
					if (rise)
						meas_r[i] <= '0;
					else if (deb_r[i])
						meas_r[i] <= meas_r[i] + 1'b1;
					if (fall)
						val_r[i] <= meas_r[i] + 1'b1;
				end
				M_BETWEEN: begin
					meas_r[i] <= rise ? '0 : meas_r[i] + 1'b1;
					if (nx_rise)
						val_r[i] <= meas_r[i] + 1'b1;
				end
				default: begin
					meas_r[i] <= '0;
					val_r[i]  <= '0;
				end
				endcase
			end
		end
		assign cur[i] = (mode == M_EVENT || mode == M_QUAD) ? cnt_r[i]
			: val_r[i];

		always_ff @(posedge CLOCK_I or negedge rst_n) begin
			if (!rst_n)
				snap_r[i] <= '0;
			else if (CE_I && scan)
				snap_r[i] <= cur[i];
		end

		always_ff @(posedge CLOCK_I or negedge rst_n) begin
			if (!rst_n)
				cfg_r[i] <= '0;
			else if (CE_I && wr && waddr == A_CNT_CFG + 8'(4 * i)) begin
				cfg_r[i] <= CFG_W'(merge(32'(cfg_r[i]), wval, wsel));
				cfg_r[i][CFG_CLR] <= 1'b0;
			end
		end
	end

	for (i = 0; i < NTMR; i++) begin : g_tmr
		logic [DIV_W-1:0] div_r;
		logic [DIV_W-1:0] pend_r;
		logic             pstop_r;
		logic             stop_r;
		logic [DIV_W:0]   hc_r;
		logic             host_wr;
		assign host_wr = wr && waddr == A_TMR_DIV + 8'(4 * i);

		always_ff @(posedge CLOCK_I or negedge rst_n) begin
			if (!rst_n) begin
				pend_r  <= '0;
				pstop_r <= 1'b1;
			end else if (CE_I) begin
				if (host_wr) begin
					pend_r  <= DIV_W'(merge(32'(tdiv_r[i]), wval, wsel));
					pstop_r <= 1'b0;
				end else if (SETPOINT_I[i] && ctrl_r[CTRL_RUN]) begin
					pend_r  <= spdiv_r[i];
					pstop_r <= spdiv_r[i] == DIV_STOP;
				end
			end
		end

		always_ff @(posedge CLOCK_I or negedge rst_n) begin
			if (!rst_n)
				tdiv_r[i] <= '0;
			else if (CE_I && host_wr)
				tdiv_r[i] <= DIV_W'(merge(32'(tdiv_r[i]), wval, wsel));
		end

		always_ff @(posedge CLOCK_I or negedge rst_n) begin
			if (!rst_n)
				spdiv_r[i] <= DIV_STOP;
			else if (CE_I && wr && waddr == A_SP_DIV + 8'(4 * i))
				spdiv_r[i] <= DIV_W'(merge(32'(spdiv_r[i]), wval, wsel));
		end

		// high for div+1 half ticks, low for div+1: 50 percent to within one clock
		always_ff @(posedge CLOCK_I or negedge rst_n) begin
			if (!rst_n) begin
				div_r    <= '0;
				stop_r   <= 1'b1;
				hc_r     <= '0;
				TMR_O[i] <= 1'b0;
			end else if (CE_I) begin
				// a stopped timer also waits for a half tick, so the
				// first high phase is never a sliver
				if (ht_r && (stop_r || hc_r == {div_r, 1'b1})) begin
					div_r    <= pend_r;
					stop_r   <= pstop_r;
					hc_r     <= '0;
					TMR_O[i] <= !pstop_r;
				end else if (ht_r) begin
					hc_r <= hc_r + 1'b1;
					if (hc_r == {1'b0, div_r})
						TMR_O[i] <= 1'b0;
				end
			end
		end
	end
	endgenerate

	// AXI4-Lite: write takes address and data together, one at a time
	assign S_AXI_AWREADY = S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID;
	assign S_AXI_WREADY  = S_AXI_AWREADY;
	assign wr    = S_AXI_AWREADY && CE_I;
	assign waddr = {S_AXI_AWADDR[7:2], 2'h0};
	assign wval  = S_AXI_WDATA;
	assign wsel  = S_AXI_WSTRB;
	assign S_AXI_ARREADY = !S_AXI_RVALID;
	assign rd = S_AXI_ARVALID && S_AXI_ARREADY && CE_I;

	always_ff @(posedge CLOCK_I or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r <= 2'h0;
			sdiv_r <= SCAN_DIV_RST;
		end else if (wr) begin
			if (waddr == A_CTRL)
				ctrl_r <= 2'(merge(32'(ctrl_r), wval, wsel));
			if (waddr == A_SCAN_DIV)
				sdiv_r <= merge(sdiv_r, wval, wsel);
		end
	end

	always_comb begin
		rdat = 32'h0000_0000;
		rerr = 1'b0;
		unique casez (S_AXI_ARADDR[7:2])
		A_CTRL[7:2]:     rdat = 32'(ctrl_r);
		A_SCAN_DIV[7:2]: rdat = sdiv_r;
		A_STATUS[7:2]:   rdat = 32'({TMR_O, g_tmr[1].stop_r,
			g_tmr[0].stop_r});
		6'b0001??:       rdat = 32'(cfg_r[S_AXI_ARADDR[3:2]]);
		6'b0010??:       rdat = cur[S_AXI_ARADDR[3:2]];
		6'b0011??:       rdat = snap_r[S_AXI_ARADDR[3:2]];
		6'b01000?:       rdat = 32'(tdiv_r[S_AXI_ARADDR[2]]);
		6'b01001?:       rdat = 32'(spdiv_r[S_AXI_ARADDR[2]]);
		default:         rerr = 1'b1;
		endcase
	end

	always_ff @(posedge CLOCK_I or negedge rst_n) begin
		if (!rst_n) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA  <= 32'h0000_0000;
			S_AXI_RRESP  <= RESP_OKAY;
		end else if (CE_I) begin
			if (rd) begin
				S_AXI_RVALID <= 1'b1;
				S_AXI_RDATA  <= rdat;
				S_AXI_RRESP  <= rerr ? RESP_SLVERR : RESP_OKAY;
			end else if (S_AXI_RREADY)
				S_AXI_RVALID <= 1'b0;
		end
	end

	always_ff @(posedge CLOCK_I or negedge rst_n) begin
		if (!rst_n) begin
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP  <= RESP_OKAY;
		end else if (CE_I) begin
			if (wr) begin
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP  <= (waddr <= A_SP_DIV + 8'h04 &&
					waddr != 8'h0C) ? RESP_OKAY : RESP_SLVERR;
			end else if (S_AXI_BREADY)
				S_AXI_BVALID <= 1'b0;
		end
	end
endmodule

/* File: common/cit_pkg.sv */
// constants for the counter inputs and timer outputs block
package cit_pkg;
	localparam int          CLK_NS       = 40;
	localparam int          CLK_MHZ      = 25;
	localparam int          HT_PER_US    = 2;
	localparam int          TB_MHZ       = 1;
	localparam int          NCNT         = 4;
	localparam int          NTMR         = 2;
	localparam int          CNT_W        = 32;
	localparam int          DIV_W        = 16;
	localparam int          DB_W         = 20;
	localparam logic [15:0] DIV_STOP     = 16'hFFFF;
	// register byte offsets
	localparam logic [7:0]  A_CTRL       = 8'h00;
	localparam logic [7:0]  A_SCAN_DIV   = 8'h04;
	localparam logic [7:0]  A_STATUS     = 8'h08;
	localparam logic [7:0]  A_CNT_CFG    = 8'h10;
	localparam logic [7:0]  A_CNT_VAL    = 8'h20;
	localparam logic [7:0]  A_SCAN_VAL   = 8'h30;
	localparam logic [7:0]  A_TMR_DIV    = 8'h40;
	localparam logic [7:0]  A_SP_DIV     = 8'h48;
	// control fields
	localparam int          CTRL_RUN     = 0;
	localparam int          CTRL_EXT     = 1;
	localparam int          CFG_MODE_LO  = 0;
	localparam int          CFG_DB_LO    = 3;
	localparam int          CFG_RES_LO   = 7;
	localparam int          CFG_CLR      = 9;
	localparam int          CFG_FALL     = 10;
	localparam int          CFG_INDEX    = 11;
	localparam int          CFG_W        = 12;
	localparam logic [31:0] SCAN_DIV_RST = 32'h0000_03E8;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;
	typedef enum logic [2:0] {
		M_EVENT   = 3'h0,
		M_PERIOD  = 3'h1,
		M_WIDTH   = 3'h2,
		M_BETWEEN = 3'h3,
		M_QUAD    = 3'h4
	} cit_mode_e;
	typedef enum logic [1:0] {
		R_X1 = 2'h0,
		R_X2 = 2'h1,
		R_X4 = 2'h2
	} cit_res_e;
	// debounce filter times in ns, sixteen settings
	localparam int DB_NS [16] = '{500, 1000, 2000, 5000, 10000, 20000,
		50000, 100000, 200000, 500000, 1000000, 2000000, 5000000,
		10000000, 20000000, 25500000};
endpackage

/* File: tb/cit_top_properties.sv */
// assertion checker for the counter and timer block
`timescale 1ns/1ps
module cit_props (
	input  wire logic        CLOCK_I,
	input  wire logic        RST_N_I,
	input  wire logic        CE_I,
	input  wire logic [1:0]  TMR_O,
	input  wire logic        SCAN_STROBE_O,
	input  wire logic        S_AXI_AWVALID,
	input  wire logic        S_AXI_AWREADY,
	input  wire logic        S_AXI_WVALID,
	input  wire logic        S_AXI_BVALID,
	input  wire logic        S_AXI_BREADY,
	input  wire logic [1:0]  S_AXI_BRESP,
	input  wire logic        S_AXI_ARVALID,
	input  wire logic        S_AXI_ARREADY,
	input  wire logic        S_AXI_RVALID,
	input  wire logic        S_AXI_RREADY,
	input  wire logic [31:0] S_AXI_RDATA
);
	logic [1:0] age_r;
	// internal reset trails the pin by two edges, so wait for it
	always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
		if (!RST_N_I)
			age_r <= 2'h0;
		else if (age_r != 2'h3)
			age_r <= age_r + 2'h1;
	end
	default clocking dc @(posedge CLOCK_I); endclocking
	default disable iff (age_r != 2'h3);
	a_read_answer: assert property (
		S_AXI_ARVALID && S_AXI_ARREADY && CE_I |=> S_AXI_RVALID)
		else $error("read not answered");
	a_read_hold: assert property (
		S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
		else $error("read data not held");
	a_ar_block: assert property (
		S_AXI_RVALID |-> !S_AXI_ARREADY)
		else $error("read taken while answer pending");
	a_write_answer: assert property (
		S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && CE_I
		|=> S_AXI_BVALID)
		else $error("write not answered");
	a_write_pair: assert property (
		S_AXI_AWREADY |-> S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID)
		else $error("write address taken alone");
	a_bresp_hold: assert property (
		S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
		else $error("write response not held");
	a_strobe_pulse: assert property (
		SCAN_STROBE_O |=> !SCAN_STROBE_O)
		else $error("scan strobe longer than one cycle");
	// half a timebase tick is at least twelve clocks
	a_tmr0_half: assert property (
		$changed(TMR_O[0]) |=> $stable(TMR_O[0])[*8])
		else $error("timer 0 half period too short");
	a_tmr1_half: assert property (
		$changed(TMR_O[1]) |=> $stable(TMR_O[1])[*8])
		else $error("timer 1 half period too short");
	c_write: cover property (S_AXI_BVALID && S_AXI_BREADY);
	c_read: cover property (S_AXI_RVALID && S_AXI_RREADY);
	c_scan: cover property (SCAN_STROBE_O);
endmodule
bind cit_top cit_props i_props (.*);

/* File: tb/cit_src.sv */
// counter input sources: pulse generator and quadrature encoder
`timescale 1ns/1ps
module cit_src (
	input  wire logic       clk_i,
	output logic      [3:0] pins_o
);
	initial pins_o = 4'h0;
	// n pulses on one pin, high and low times in clocks
	task automatic pulse(input int ch, input int n, input int hi, input int lo);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_i);
			pins_o[ch] <= 1'b1;
			repeat (hi) @(posedge clk_i);
			pins_o[ch] <= 1'b0;
			repeat (lo) @(posedge clk_i);
		end
	endtask
	// pin 0 leads pin 1, four steps per full cycle
	task automatic quad(input int n);
		logic [1:0] s [4] = '{2'h1, 2'h3, 2'h2, 2'h0};
		for (int i = 0; i < 4 * n; i++) begin
			repeat (8) @(posedge clk_i);
			pins_o[1:0] <= s[i % 4];
		end
	endtask
endmodule

/* File: tb/testbench.sv */
// self-checking bench for the counter and timer block
`timescale 1ns/1ps
module testbench;
	import cit_pkg::*;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        pacer = 1'b0;
	logic [1:0]  sp = 2'h0;
	logic [3:0]  pins;
	logic [1:0]  tmr;
	logic        strobe;
	logic [7:0]  aw_a = 8'h00;
	logic [7:0]  ar_a = 8'h00;
	logic [31:0] w_d = 32'h0;
	logic        awv = 1'b0;
	logic        wv = 1'b0;
	logic        br = 1'b0;
	logic        arv = 1'b0;
	logic        rr = 1'b0;
	logic        aw_rdy, w_rdy, b_v, ar_rdy, r_v;
	logic [1:0]  b_resp, r_resp;
	logic [31:0] r_d;
	int          failures = 0;
	int          cmp_count = 0;
	always #20 clk = ~clk;
	cit_src i_src (.clk_i(clk), .pins_o(pins));
	cit_top #(.DB_DIV(1000)) i_dut (
		.CLOCK_I(clk), .RST_N_I(rst_n), .CE_I(1'b1), .CNT_IN_I(pins),
		.EXT_PACER_I(pacer), .SETPOINT_I(sp), .TMR_O(tmr),
		.SCAN_STROBE_O(strobe), .S_AXI_AWADDR(aw_a), .S_AXI_AWVALID(awv),
		.S_AXI_AWREADY(aw_rdy), .S_AXI_WDATA(w_d), .S_AXI_WSTRB(4'hF),
		.S_AXI_WVALID(wv), .S_AXI_WREADY(w_rdy), .S_AXI_BRESP(b_resp),
		.S_AXI_BVALID(b_v), .S_AXI_BREADY(br), .S_AXI_ARADDR(ar_a),
		.S_AXI_ARVALID(arv), .S_AXI_ARREADY(ar_rdy), .S_AXI_RDATA(r_d),
		.S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_v), .S_AXI_RREADY(rr));
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// handshakes are judged at the rising edge; only the watchdog ends a wait
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic tb;
		@(posedge clk);
		aw_a <= a;
		w_d <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		tb = 1'b0;
		while (!tb) begin
			@(posedge clk);
			if (awv && aw_rdy)
				awv <= 1'b0;
			if (wv && w_rdy)
				wv <= 1'b0;
			tb = b_v;
			r = b_resp;
		end
		br <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic tb;
		@(posedge clk);
		ar_a <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		tb = 1'b0;
		while (!tb) begin
			@(posedge clk);
			if (arv && ar_rdy)
				arv <= 1'b0;
			tb = r_v;
			d = r_d;
			r = r_resp;
		end
		rr <= 1'b0;
	endtask
	task automatic ck(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		chk(d, e);
		chk({30'h0, r}, {30'h0, RESP_OKAY});
	endtask
	task automatic wt(input int t, input logic v, output int n);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (tmr[t] !== v && n < 9000);
	endtask
	task automatic wst(input int lim);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (strobe !== 1'b1 && n < lim);
		chk({31'h0, strobe}, 32'h1);
	endtask
	task automatic give_verdict;
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// the tests need about 4600 clocks
	initial begin
		#(40 * 60000);
		failures++;
		give_verdict;
	end
	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		int          n, a, b;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		ck(A_CTRL, 32'h0);
		ck(A_SCAN_DIV, SCAN_DIV_RST);
		ck(A_SP_DIV, {16'h0, DIV_STOP});
		ck(A_STATUS, 32'h3);
		rd(8'h7C, d, r);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		chk(d, 32'h0);
		wr(8'h7C, 32'h1, r);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		for (int m = 0; m < 5; m++) begin
			wr(A_CNT_CFG + 8'hC, 32'(m), r);
			ck(A_CNT_CFG + 8'hC, 32'(m));
		end
		$display("test registers done");
		for (int q = 0; q < 3; q++) begin
			wr(A_CNT_CFG, 32'h204 | (32'(q) << CFG_RES_LO), r);
			i_src.quad(3);
			repeat (10) @(posedge clk);
			ck(A_CNT_VAL, 32'(3 << q));
		end
		wr(A_CNT_CFG + 8'h4, 32'h200, r);
		i_src.pulse(1, 5, 4, 4);
		repeat (10) @(posedge clk);
		ck(A_CNT_VAL + 8'h4, 32'h5);
		// slowest filter: 200 clock glitches vanish, 900 clocks pass
		wr(A_CNT_CFG + 8'h4, 32'h278, r);
		i_src.pulse(1, 3, 200, 200);
		i_src.pulse(1, 1, 900, 900);
		ck(A_CNT_VAL + 8'h4, 32'h1);
		// pulse source: high for hi clocks, low for lo plus one
		wr(A_CNT_CFG + 8'h8, 32'(M_PERIOD), r);
		i_src.pulse(2, 3, 5, 5);
		ck(A_CNT_VAL + 8'h8, 32'h0000_000B);
		wr(A_CNT_CFG + 8'h8, 32'(M_WIDTH), r);
		i_src.pulse(2, 2, 5, 5);
		ck(A_CNT_VAL + 8'h8, 32'h0000_0005);
		$display("test counting done");
		wr(A_CTRL, 32'h3, r);
		// short pin pulse so the strobe watch starts before the strobe
		pacer <= 1'b1;
		repeat (2) @(posedge clk);
		pacer <= 1'b0;
		wst(60);
		ck(A_SCAN_VAL + 8'h4, 32'h1);
		wr(A_SCAN_DIV, 32'h2, r);
		wr(A_CTRL, 32'h1, r);
		wst(200);
		$display("test scan done");
		for (int t = 0; t < 2; t++)
			for (int v = 0; v < 3; v++) begin
				wr(A_TMR_DIV + 8'(4 * t), 32'(v * v), r);
				wt(t, 1'b0, n);
				wt(t, 1'b1, n);
				wt(t, 1'b0, a);
				wt(t, 1'b1, b);
				chk(32'(a + b), 32'(25 * (v * v + 1)));
			end
		@(posedge clk);
		sp <= 2'h2;
		@(posedge clk);
		sp <= 2'h0;
		repeat (300) @(posedge clk);
		rd(A_STATUS, d, r);
		chk({31'h0, d[1]}, 32'h1);
		chk({31'h0, tmr[1]}, 32'h0);
		wr(A_TMR_DIV + 8'h4, {16'h0, DIV_STOP}, r);
		repeat (100) @(posedge clk);
		rd(A_STATUS, d, r);
		chk({31'h0, d[1]}, 32'h0);
		$display("test timers done");
		give_verdict;
	end
endmodule
